// ### hw/pwmu_pkg.sv
package pwmu_pkg;
  // Sizes
  localparam int NGEN  = 4;
  localparam int CNT_W = 16;
  localparam int EVT_W = 6;
  localparam int INT_W = 5;
  localparam int ADR_W = 12;

  // Global register byte offsets
  localparam logic [11:0] SYNC_OFS  = 12'h000;
  localparam logic [11:0] OUTEN_OFS = 12'h004;
  localparam logic [11:0] INV_OFS   = 12'h008;
  localparam logic [11:0] FSEL_OFS  = 12'h00c;
  localparam logic [11:0] RIS_OFS   = 12'h010;
  localparam logic [11:0] IEN_OFS   = 12'h014;
  localparam logic [11:0] ICLR_OFS  = 12'h018;
  localparam logic [11:0] MIS_OFS   = 12'h01c;

  // Generator windows: base plus stride times generator index
  localparam logic [11:0] GEN_BASE  = 12'h100;
  localparam logic [4:0]  GCTL_OFS  = 5'h00;
  localparam logic [4:0]  LOAD_OFS  = 5'h04;
  localparam logic [4:0]  CMPA_OFS  = 5'h08;
  localparam logic [4:0]  CMPB_OFS  = 5'h0c;
  localparam logic [4:0]  RISE_OFS  = 5'h10;
  localparam logic [4:0]  FALL_OFS  = 5'h14;
  localparam logic [4:0]  CNT_OFS   = 5'h18;
  localparam logic [4:0]  EVEN_OFS  = 5'h1c;

  // Generator control bits
  localparam int CTL_EN   = 0;
  localparam int CTL_UD   = 1;
  localparam int CTL_SYNC = 2;
  localparam int CTL_DB   = 3;

  // Event bits: zero, load, A up, A down, B up, B down
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_AU   = 2;
  localparam int EV_AD   = 3;
  localparam int EV_BU   = 4;
  localparam int EV_BD   = 5;
  localparam int TRG_POS = 8;

  // Interrupt status layout: generators in low bits, fault above
  localparam int INT_FAULT = 4;

  // Reset values
  localparam logic [3:0]  CTL_RST = 4'h0;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [7:0]  OUT_RST = 8'h00;
endpackage : pwmu_pkg

// ### hw/pwmu_gen_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pwmu_gen_if;
  logic                       enable;
  logic                       updown;
  logic                       db_en;
  logic                       upd_ok;
  logic [pwmu_pkg::CNT_W-1:0] load_pend;
  logic [pwmu_pkg::CNT_W-1:0] cmpa_pend;
  logic [pwmu_pkg::CNT_W-1:0] cmpb_pend;
  logic [pwmu_pkg::CNT_W-1:0] rise;
  logic [pwmu_pkg::CNT_W-1:0] fall;
  logic [pwmu_pkg::CNT_W-1:0] count;
  logic [pwmu_pkg::CNT_W-1:0] load_act;
  logic                       out_a;
  logic                       out_b;
  logic                       applied;
  logic [pwmu_pkg::EVT_W-1:0] events;

  modport ctl (output enable, updown, db_en, upd_ok, load_pend, cmpa_pend, cmpb_pend,
               rise, fall, input count, load_act, out_a, out_b, applied, events);
  modport gen (input enable, updown, db_en, upd_ok, load_pend, cmpa_pend, cmpb_pend,
               rise, fall, output count, load_act, out_a, out_b, applied, events);
endinterface : pwmu_gen_if
`default_nettype wire

// ### hw/pwmu_generator.sv
`timescale 1ns/1ns
`default_nettype none
module pwmu_generator (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration in, state out
  pwmu_gen_if.gen  gif
);
  logic [pwmu_pkg::CNT_W-1:0] cnt_reg;
  logic [pwmu_pkg::CNT_W-1:0] load_reg;
  logic [pwmu_pkg::CNT_W-1:0] cmpa_reg;
  logic [pwmu_pkg::CNT_W-1:0] cmpb_reg;
  logic [pwmu_pkg::CNT_W-1:0] dcnt_reg;
  logic                       up_reg;
  logic                       a_prev_reg;
  logic                       out_a_reg;
  logic                       out_b_reg;
  logic                       applied_reg;
  logic [pwmu_pkg::CNT_W-1:0] load_next;
  logic                       at_zero;
  logic                       a_raw;
  logic                       b_raw;
  logic [pwmu_pkg::CNT_W-1:0] run_len;

  // Shadow values move in only at zero and when allowed
  assign at_zero   = gif.enable && (cnt_reg == pwmu_pkg::VAL_RST);
  assign load_next = gif.upd_ok ? gif.load_pend : load_reg;
  assign a_raw     = cnt_reg > cmpa_reg;
  assign b_raw     = cnt_reg > cmpb_reg;

  // Ticks the first raw output has held its level, zero on the edge itself
  assign run_len   = (a_raw != a_prev_reg) ? pwmu_pkg::VAL_RST : dcnt_reg;

  // Counter: holds while disabled, down or up/down otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg <= pwmu_pkg::VAL_RST;
      up_reg  <= 1'h0;
    end else if (gif.enable) begin
      if (!gif.updown) begin
        up_reg  <= 1'h0;
        cnt_reg <= at_zero ? load_next : cnt_reg - 16'h0001;
      end else if (up_reg) begin
        if (cnt_reg >= load_reg) begin
          up_reg  <= 1'h0;
          cnt_reg <= cnt_reg - 16'h0001;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end else if (at_zero) begin
        if (load_next != pwmu_pkg::VAL_RST) begin
          up_reg  <= 1'h1;
          cnt_reg <= 16'h0001;
        end
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  // Active period and widths
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      load_reg    <= pwmu_pkg::VAL_RST;
      cmpa_reg    <= pwmu_pkg::VAL_RST;
      cmpb_reg    <= pwmu_pkg::VAL_RST;
      applied_reg <= 1'h0;
    end else begin
      applied_reg <= at_zero && gif.upd_ok;
      if (at_zero && gif.upd_ok) begin
        load_reg <= gif.load_pend;
        cmpa_reg <= gif.cmpa_pend;
        cmpb_reg <= gif.cmpb_pend;
      end
    end
  end

  // Dead band: ticks since the last edge of the first output
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      a_prev_reg <= 1'h0;
      dcnt_reg   <= pwmu_pkg::VAL_RST;
      out_a_reg  <= 1'h0;
      out_b_reg  <= 1'h0;
    end else begin
      a_prev_reg <= a_raw;
      if (a_raw != a_prev_reg) begin
        dcnt_reg <= 16'h0001;
      end else if (dcnt_reg != 16'hffff) begin
        dcnt_reg <= dcnt_reg + 16'h0001;
      end
      if (gif.db_en) begin
        out_a_reg <= a_raw && (run_len >= gif.rise);
        out_b_reg <= !a_raw && (run_len >= gif.fall);
      end else begin
        out_a_reg <= a_raw;
        out_b_reg <= b_raw;
      end
    end
  end

  // Events from counter and comparators
  assign gif.events[pwmu_pkg::EV_ZERO] = at_zero;
  assign gif.events[pwmu_pkg::EV_LOAD] = gif.enable && (cnt_reg == load_reg);
  assign gif.events[pwmu_pkg::EV_AU]   = gif.enable && up_reg && (cnt_reg == cmpa_reg);
  assign gif.events[pwmu_pkg::EV_AD]   = gif.enable && !up_reg && (cnt_reg == cmpa_reg);
  assign gif.events[pwmu_pkg::EV_BU]   = gif.enable && up_reg && (cnt_reg == cmpb_reg);
  assign gif.events[pwmu_pkg::EV_BD]   = gif.enable && !up_reg && (cnt_reg == cmpb_reg);
  assign gif.count    = cnt_reg;
  assign gif.load_act = load_reg;
  assign gif.out_a    = out_a_reg;
  assign gif.out_b    = out_b_reg;
  assign gif.applied  = applied_reg;
endmodule : pwmu_generator
`default_nettype wire

// ### hw/pwmu_top.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module pwmu_top #(
  parameter int NGEN = pwmu_pkg::NGEN
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pwmu_pkg::ADR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Fault pin
  input  wire logic                        fault_in,
  // Outputs to the power stage
  output logic      [2*NGEN-1:0]           pwm_out,
  output logic      [NGEN-1:0]             trig_out,
  output logic                             irq
);
  logic [31:0]                prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;
  logic [2*NGEN-1:0]          pwm_reg;
  logic [NGEN-1:0]            trig_reg;
  logic                       irq_reg;
  logic [2*NGEN-1:0]          outen_reg;
  logic [2*NGEN-1:0]          inv_reg;
  logic [2*NGEN-1:0]          fsel_reg;
  logic [pwmu_pkg::INT_W-1:0] ien_reg;
  logic [pwmu_pkg::INT_W-1:0] ris_reg;
  logic [NGEN-1:0]            syncp_reg;
  logic                       fault_s1_reg;
  logic                       fault_s2_reg;
  logic                       acc_ph;
  logic                       wr_fire;
  logic                       gen_region;
  logic [4:0]                 gofs;
  logic [31:0]                rdata_next;
  logic                       mapped;
  logic [2*NGEN-1:0]          raw_out;
  logic [NGEN-1:0]            gen_int;
  logic [NGEN-1:0]            gen_trg;
  logic [NGEN-1:0]            gen_applied;
  logic [pwmu_pkg::INT_W-1:0] int_set;
  logic [pwmu_pkg::INT_W-1:0] int_clr;
  logic [31:0]                gen_rd [NGEN];

  pwmu_gen_if gif [NGEN] ();

  // Bus phase decode; writes land at the edge that samples pready
  assign acc_ph     = psel && penable;
  assign wr_fire    = acc_ph && pready_reg && pwrite;
  assign gen_region = paddr[11:7] == pwmu_pkg::GEN_BASE[11:7];
  assign gofs       = paddr[4:0];

  // Per-generator registers, generator and event taps
  for (genvar k = 0; k < NGEN; k++) begin : g_gen
    logic [3:0]                 ctl_reg;
    logic [pwmu_pkg::CNT_W-1:0] load_reg;
    logic [pwmu_pkg::CNT_W-1:0] cmpa_reg;
    logic [pwmu_pkg::CNT_W-1:0] cmpb_reg;
    logic [pwmu_pkg::CNT_W-1:0] rise_reg;
    logic [pwmu_pkg::CNT_W-1:0] fall_reg;
    logic [pwmu_pkg::EVT_W-1:0] iev_reg;
    logic [pwmu_pkg::EVT_W-1:0] tev_reg;
    logic                       sel;

    assign sel = gen_region && (paddr[6:5] == 2'(k));

    // Software view of this generator
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        ctl_reg  <= pwmu_pkg::CTL_RST;
        load_reg <= pwmu_pkg::VAL_RST;
        cmpa_reg <= pwmu_pkg::VAL_RST;
        cmpb_reg <= pwmu_pkg::VAL_RST;
        rise_reg <= pwmu_pkg::VAL_RST;
        fall_reg <= pwmu_pkg::VAL_RST;
        iev_reg  <= '0;
        tev_reg  <= '0;
      end else if (wr_fire && sel) begin
        unique case (gofs)
          pwmu_pkg::GCTL_OFS: ctl_reg  <= pwdata[3:0];
          pwmu_pkg::LOAD_OFS: load_reg <= pwdata[15:0];
          pwmu_pkg::CMPA_OFS: cmpa_reg <= pwdata[15:0];
          pwmu_pkg::CMPB_OFS: cmpb_reg <= pwdata[15:0];
          pwmu_pkg::RISE_OFS: rise_reg <= pwdata[15:0];
          pwmu_pkg::FALL_OFS: fall_reg <= pwdata[15:0];
          pwmu_pkg::EVEN_OFS: begin
            iev_reg <= pwdata[pwmu_pkg::EVT_W-1:0];
            tev_reg <= pwdata[pwmu_pkg::TRG_POS +: pwmu_pkg::EVT_W];
          end
          default: ;
        endcase
      end
    end

    // Configuration towards the generator
    assign gif[k].enable    = ctl_reg[pwmu_pkg::CTL_EN];
    assign gif[k].updown    = ctl_reg[pwmu_pkg::CTL_UD];
    assign gif[k].db_en     = ctl_reg[pwmu_pkg::CTL_DB];
    assign gif[k].upd_ok    = !ctl_reg[pwmu_pkg::CTL_SYNC] || syncp_reg[k];
    assign gif[k].load_pend = load_reg;
    assign gif[k].cmpa_pend = cmpa_reg;
    assign gif[k].cmpb_pend = cmpb_reg;
    assign gif[k].rise      = rise_reg;
    assign gif[k].fall      = fall_reg;

    pwmu_generator u_gen (
      .clock (clock),
      .rst_n (rst_n),
      .gif   (gif[k])
    );

    // Outputs 2k and 2k+1 belong to generator k
    assign raw_out[2*k]   = gif[k].out_a;
    assign raw_out[2*k+1] = gif[k].out_b;
    assign gen_int[k]     = |(gif[k].events & iev_reg);
    assign gen_trg[k]     = |(gif[k].events & tev_reg);
    assign gen_applied[k] = gif[k].applied;

    // Read view of this generator
    assign gen_rd[k] =
      (gofs == pwmu_pkg::GCTL_OFS) ? {28'h0000000, ctl_reg} :
      (gofs == pwmu_pkg::LOAD_OFS) ? {16'h0000, load_reg} :
      (gofs == pwmu_pkg::CMPA_OFS) ? {16'h0000, cmpa_reg} :
      (gofs == pwmu_pkg::CMPB_OFS) ? {16'h0000, cmpb_reg} :
      (gofs == pwmu_pkg::RISE_OFS) ? {16'h0000, rise_reg} :
      (gofs == pwmu_pkg::FALL_OFS) ? {16'h0000, fall_reg} :
      (gofs == pwmu_pkg::CNT_OFS)  ? {16'h0000, gif[k].count} :
      {18'h00000, tev_reg, 2'h0, iev_reg};

    // Counter holds while the generator is disabled
    a_hold_count: assert property (
      @(posedge clock) disable iff (!rst_n)
      !gif[k].enable |=> $stable(gif[k].count))
      else $error("Counter moved while disabled");

    // Down mode steps by one
    a_down_step: assert property (
      @(posedge clock) disable iff (!rst_n)
      gif[k].enable && !gif[k].updown && gif[k].count != 16'h0000
      |=> gif[k].count == $past(gif[k].count) - 16'h0001)
      else $error("Down count did not step by one");

    // Down mode reloads to the active period at zero
    a_down_wrap: assert property (
      @(posedge clock) disable iff (!rst_n)
      gif[k].enable && !gif[k].updown && gif[k].count == 16'h0000
      |=> gif[k].count == gif[k].load_act)
      else $error("Down count did not reload at zero");

    // Active period changes only from a zero count
    a_update_zero: assert property (
      @(posedge clock) disable iff (!rst_n)
      $changed(gif[k].load_act) |-> $past(gif[k].count) == 16'h0000 && $past(gif[k].enable))
      else $error("Period changed away from zero");

    // Sync mode holds the old period until the sync event
    a_sync_wait: assert property (
      @(posedge clock) disable iff (!rst_n)
      !gif[k].upd_ok |=> $stable(gif[k].load_act))
      else $error("Period applied without sync event");

    // Dead band pair is never high together
    a_db_overlap: assert property (
      @(posedge clock) disable iff (!rst_n)
      gif[k].db_en && $past(gif[k].db_en) |-> !(gif[k].out_a && gif[k].out_b))
      else $error("Dead band outputs overlap");

    // Trigger follows enabled events by one cycle
    a_trig_event: assert property (
      @(posedge clock) disable iff (!rst_n)
      gen_trg[k] |=> trig_out[k])
      else $error("Trigger missed an enabled event");

    c_updown_peak: cover property (
      @(posedge clock) disable iff (!rst_n)
      gif[k].updown && gif[k].events[pwmu_pkg::EV_LOAD] ##1 gif[k].events[pwmu_pkg::EV_AD]);
  end

  // Fault pin synchroniser
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_s1_reg <= 1'h0;
      fault_s2_reg <= 1'h0;
    end else begin
      fault_s1_reg <= fault_in;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  // Global read mux and address map
  always_comb begin
    rdata_next = 32'h00000000;
    mapped     = paddr[1:0] == 2'h0;
    if (gen_region) begin
      rdata_next = gen_rd[paddr[6:5]];
    end else begin
      unique case (paddr)
        pwmu_pkg::SYNC_OFS:  rdata_next = {28'h0000000, syncp_reg};
        pwmu_pkg::OUTEN_OFS: rdata_next = {24'h000000, outen_reg};
        pwmu_pkg::INV_OFS:   rdata_next = {24'h000000, inv_reg};
        pwmu_pkg::FSEL_OFS:  rdata_next = {24'h000000, fsel_reg};
        pwmu_pkg::RIS_OFS:   rdata_next = {27'h0000000, ris_reg};
        pwmu_pkg::IEN_OFS:   rdata_next = {27'h0000000, ien_reg};
        pwmu_pkg::ICLR_OFS:  rdata_next = 32'h00000000;
        pwmu_pkg::MIS_OFS:   rdata_next = {27'h0000000, ris_reg & ien_reg};
        default:             mapped     = 1'h0;
      endcase
    end
  end

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_reg  <= 1'h0;
      pslverr_reg <= 1'h0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= acc_ph && !pready_reg;
      pslverr_reg <= acc_ph && !pready_reg && !mapped;
      prdata_reg  <= (acc_ph && !pready_reg && !pwrite && mapped) ? rdata_next : 32'h00000000;
    end
  end

  // Output control and interrupt enable registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outen_reg <= pwmu_pkg::OUT_RST;
      inv_reg   <= pwmu_pkg::OUT_RST;
      fsel_reg  <= pwmu_pkg::OUT_RST;
      ien_reg   <= '0;
    end else if (wr_fire && !gen_region) begin
      if (paddr == pwmu_pkg::OUTEN_OFS) outen_reg <= pwdata[2*NGEN-1:0];
      if (paddr == pwmu_pkg::INV_OFS)   inv_reg   <= pwdata[2*NGEN-1:0];
      if (paddr == pwmu_pkg::FSEL_OFS)  fsel_reg  <= pwdata[2*NGEN-1:0];
      if (paddr == pwmu_pkg::IEN_OFS)   ien_reg   <= pwdata[pwmu_pkg::INT_W-1:0];
    end
  end

  // Sync requests wait for the generator to apply at zero; a new request wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncp_reg <= '0;
    end else begin
      syncp_reg <= (syncp_reg & ~gen_applied) |
                   ((wr_fire && paddr == pwmu_pkg::SYNC_OFS) ? pwdata[NGEN-1:0] : '0);
    end
  end

  // Sticky interrupt status, set beats clear
  assign int_set = {fault_s2_reg, gen_int};
  assign int_clr = (wr_fire && paddr == pwmu_pkg::ICLR_OFS) ? pwdata[pwmu_pkg::INT_W-1:0] : '0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ris_reg <= '0;
      irq_reg <= 1'h0;
    end else begin
      ris_reg <= (ris_reg & ~int_clr) | int_set;
      irq_reg <= |(ris_reg & ien_reg);
    end
  end

  // Polarity, fault blanking and pass gate per output
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwm_reg  <= '0;
      trig_reg <= '0;
    end else begin
      pwm_reg  <= outen_reg & ~(fault_s2_reg ? fsel_reg : '0) & (raw_out ^ inv_reg);
      trig_reg <= gen_trg;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign pwm_out  = pwm_reg;
  assign trig_out = trig_reg;
  assign irq      = irq_reg;

  // Interrupt output follows the masked status
  a_irq_level: assert property (
    @(posedge clock) disable iff (!rst_n)
    (|(ris_reg & ien_reg)) |=> irq)
    else $error("Masked status set but no interrupt");

  // Blocked outputs stay low
  a_out_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    outen_reg == 8'h00 |=> pwm_out == 8'h00)
    else $error("Output passed while disabled");

  // Fault blanks the selected outputs one cycle on
  a_fault_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    fault_s2_reg |=> (pwm_out & $past(fsel_reg)) == 8'h00)
    else $error("Selected output passed during fault");

  // Interrupt drops once no enabled status bit is set
  a_irq_low: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(|(ris_reg & ien_reg)) |=> !irq)
    else $error("Interrupt high with no masked status");

  c_irq_rise: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq));
  c_fault_blank: cover property (@(posedge clock) disable iff (!rst_n)
    fault_s2_reg && fsel_reg != 8'h00);
  c_sync_apply: cover property (@(posedge clock) disable iff (!rst_n)
    |(syncp_reg & gen_applied));
endmodule : pwmu_top
`default_nettype wire

// ### testbench/pwmu_load_model.sv
`timescale 1ns/1ns
`default_nettype none
module pwmu_load_model (
  // Clock
  input wire logic       clock,
  // Lines from the unit
  input wire logic [7:0] pwm_out,
  input wire logic [3:0] trig_out
);
  int         since_rise [8];
  int         hi_cnt     [8];
  int         width      [8];
  int         period     [8];
  int         trig_cnt   [4];
  logic [7:0] prev = 8'h00;

  // Measure high time and rise-to-rise period of each line, count triggers
  always @(posedge clock) begin
    for (int i = 0; i < 8; i++) begin
      if (pwm_out[i] && !prev[i]) begin
        period[i]     = since_rise[i];
        since_rise[i] = 0;
      end
      since_rise[i]++;
      if (pwm_out[i]) hi_cnt[i]++;
      else if (prev[i]) begin
        width[i]  = hi_cnt[i];
        hi_cnt[i] = 0;
      end
    end
    for (int k = 0; k < 4; k++) if (trig_out[k]) trig_cnt[k]++;
    prev = pwm_out;
  end
endmodule : pwmu_load_model
`default_nettype wire

// ### testbench/multi_generator_pwm_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module multi_generator_pwm_unit_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fault_in = 1'b0;
  logic [7:0]  pwm_out;
  logic [3:0]  trig_out;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        err;
  logic [7:0]  seen;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          t0;

  // 100 MHz clock
  always #5 clock = ~clock;

  pwmu_top DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .pwm_out(pwm_out), .trig_out(trig_out), .irq(irq));

  pwmu_load_model load (.clock(clock), .pwm_out(pwm_out), .trig_out(trig_out));

  // One APB transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock iff (pready === 1'b1));
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // Generator register address
  function automatic logic [11:0] ga(input int k, input logic [4:0] ofs);
    return pwmu_pkg::GEN_BASE + 12'(32 * k) + 12'(ofs);
  endfunction : ga

  // Collect every output bit that went high over n cycles
  task automatic watch(input int n);
    seen = 8'h00;
    repeat (n) begin
      @(posedge clock);
      seen = seen | pwm_out;
    end
  endtask : watch

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    complete_run();
  end

  // Test sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, pwmu_pkg::RIS_OFS, 32'h0);
    `CHECK("raw status reset", 32'h0000_0000, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHECK("unmapped err", 1'b1, err)
    // Generator_zero down, generator_one up/down, generator_two dead band, generator_three off
    apb(1'b1, pwmu_pkg::OUTEN_OFS, 32'h0000_00ff);
    apb(1'b1, ga(0, pwmu_pkg::LOAD_OFS), 32'd3);
    apb(1'b1, ga(0, pwmu_pkg::CMPA_OFS), 32'd1);
    apb(1'b1, ga(1, pwmu_pkg::LOAD_OFS), 32'd4);
    apb(1'b1, ga(1, pwmu_pkg::CMPA_OFS), 32'd2);
    apb(1'b1, ga(1, pwmu_pkg::CMPB_OFS), 32'd1);
    apb(1'b1, ga(2, pwmu_pkg::LOAD_OFS), 32'd7);
    apb(1'b1, ga(2, pwmu_pkg::CMPA_OFS), 32'd3);
    apb(1'b1, ga(2, pwmu_pkg::RISE_OFS), 32'd1);
    apb(1'b1, ga(2, pwmu_pkg::FALL_OFS), 32'd1);
    apb(1'b1, ga(0, pwmu_pkg::GCTL_OFS), 32'h1);
    apb(1'b1, ga(1, pwmu_pkg::GCTL_OFS), 32'h3);
    apb(1'b1, ga(2, pwmu_pkg::GCTL_OFS), 32'h9);
    watch(60);
    `CHECK("generator_zero period", 4, load.period[0])
    `CHECK("generator_zero first width", 2, load.width[0])
    `CHECK("generator_zero second width", 3, load.width[1])
    `CHECK("generator_one period", 8, load.period[2])
    `CHECK("generator_one first width", 3, load.width[2])
    `CHECK("generator_one second width", 5, load.width[3])
    `CHECK("generator_two first width", 3, load.width[4])
    `CHECK("generator_two second period", 8, load.period[5])
    `CHECK("generator_two second width", 3, load.width[5])
    `CHECK("generator_three idle", 2'b00, seen[7:6])
    // New period reaches the output at a zero crossing
    apb(1'b1, ga(0, pwmu_pkg::LOAD_OFS), 32'd5);
    watch(30);
    `CHECK("generator_zero new period", 6, load.period[0])
    `CHECK("generator_zero new width", 4, load.width[0])
    // Sync mode holds values until a sync request
    apb(1'b1, ga(3, pwmu_pkg::LOAD_OFS), 32'd3);
    apb(1'b1, ga(3, pwmu_pkg::CMPA_OFS), 32'd1);
    apb(1'b1, ga(3, pwmu_pkg::GCTL_OFS), 32'h5);
    watch(20);
    `CHECK("generator_three waits sync", 1'b0, seen[6])
    apb(1'b1, pwmu_pkg::SYNC_OFS, 32'h8);
    watch(30);
    `CHECK("generator_three after sync", 4, load.period[6])
    // Disabled generator holds its counter
    apb(1'b1, ga(0, pwmu_pkg::GCTL_OFS), 32'h0);
    apb(1'b0, ga(0, pwmu_pkg::CNT_OFS), 32'h0);
    rd2 = rd;
    repeat (10) @(posedge clock);
    apb(1'b0, ga(0, pwmu_pkg::CNT_OFS), 32'h0);
    `CHECK("generator_zero count held", rd2, rd)
    // Polarity and pass control
    apb(1'b1, pwmu_pkg::INV_OFS, 32'h0000_0004);
    apb(1'b1, pwmu_pkg::OUTEN_OFS, 32'h0000_00ef);
    watch(30);
    `CHECK("generator_one inverted width", 5, load.width[2])
    `CHECK("line4 gated", 1'b0, seen[4])
    // Interrupt from generator_one zero events, trigger from zero and load events
    apb(1'b1, ga(1, pwmu_pkg::EVEN_OFS), 32'h0000_0301);
    apb(1'b1, pwmu_pkg::IEN_OFS, 32'h0000_0002);
    t0 = load.trig_cnt[1];
    repeat (16) @(posedge clock);
    `CHECK("generator_one triggers", t0 + 4, load.trig_cnt[1])
    `CHECK("irq set", 1'b1, irq)
    apb(1'b0, pwmu_pkg::MIS_OFS, 32'h0);
    `CHECK("masked status", 32'h0000_0002, rd)
    apb(1'b1, pwmu_pkg::IEN_OFS, 32'h0);
    repeat (2) @(posedge clock);
    `CHECK("irq masked", 1'b0, irq)
    apb(1'b1, ga(1, pwmu_pkg::GCTL_OFS), 32'h0);
    apb(1'b1, pwmu_pkg::ICLR_OFS, 32'h0000_0002);
    apb(1'b0, pwmu_pkg::RIS_OFS, 32'h0);
    `CHECK("status cleared", 32'h0000_0000, rd)
    // Fault forces selected line low and sets its status
    apb(1'b1, pwmu_pkg::FSEL_OFS, 32'h0000_0001);
    apb(1'b1, ga(0, pwmu_pkg::GCTL_OFS), 32'h1);
    fault_in <= 1'b1;
    repeat (4) @(posedge clock);
    watch(20);
    `CHECK("fault gate", 1'b0, seen[0])
    apb(1'b0, pwmu_pkg::RIS_OFS, 32'h0);
    `CHECK("fault status", 32'h0000_0010, rd)
    fault_in <= 1'b0;
    complete_run();
  end
endmodule : multi_generator_pwm_unit_tb
`default_nettype wire
